// ===== diffserv_pkg.sv
package diffserv_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [15:0] MAP_LOW_OFFSET   = 16'h8300;
    localparam logic [15:0] MAP_HIGH_OFFSET  = 16'h8304;
    localparam logic [31:0] MAP_LOW_RESET    = 32'h0000_0000;
    localparam logic [31:0] MAP_HIGH_RESET   = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

    // =====================================================================
    // Field layout
    // =====================================================================
    localparam int unsigned TOS_CODE_MSB     = 7;
    localparam int unsigned TOS_CODE_LSB     = 2;
    localparam int unsigned CODE_WIDTH       = 6;
    localparam int unsigned CODE_COUNT       = 64;
    localparam logic [5:0]  HIGH_BANK_BASE   = 6'h20;

    typedef struct packed {
        logic       valid;
        logic       is_ipv4;
        logic       is_ipv6;
        logic [7:0] tos;
    } frame_info_type;

    typedef struct packed {
        logic       valid;
        logic       high_priority;
        logic [5:0] code;
    } prio_result_type;

endpackage

// ===== diffserv_priority_lookup.sv
// Notes on behaviour
// - The six upper traffic-class bits are decoded one-hot into 64 codes and select one table bit.
// - A selected table bit of one marks the frame high priority, zero marks it low.
// - In the lower map register bit n gives the priority of code n, for codes 0x00 to 0x1F.
// - IPv4 and IPv6 frames use the same table, taking the traffic-class field of the header present.
// - The lower map register sits at 0x8300, is 32 bits read-write and resets to zero.
// - The upper map register at 0x8304 holds codes 0x20 to 0x3F, bit n for code 0x20 plus n, reset zero.
module diffserv_priority_lookup (
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           clk_en,
    input  wire logic [15:0]                    wb_adr_i,
    input  wire logic [31:0]                    wb_dat_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic                           wb_we_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    input  wire diffserv_pkg::frame_info_type   frame_in,
    output diffserv_pkg::prio_result_type       result_out
);

    // =====================================================================
    // Register bus
    // =====================================================================
    logic [31:0]                    map_low_r;
    logic [31:0]                    map_high_r;
    logic [31:0]                    map_low_nxt;
    logic [31:0]                    map_high_nxt;
    logic [31:0]                    rd_data_nxt;
    logic [31:0]                    byte_mask;
    logic                           bus_req;
    logic                           wr_take;
    logic                           hit_low;
    logic                           hit_high;

    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_take   = bus_req && wb_we_i;
    assign hit_low   = (wb_adr_i == diffserv_pkg::MAP_LOW_OFFSET);
    assign hit_high  = (wb_adr_i == diffserv_pkg::MAP_HIGH_OFFSET);
    assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    assign map_low_nxt  = (wr_take && hit_low)
                        ? ((map_low_r & ~byte_mask) | (wb_dat_i & byte_mask))
                        : map_low_r;
    assign map_high_nxt = (wr_take && hit_high)
                        ? ((map_high_r & ~byte_mask) | (wb_dat_i & byte_mask))
                        : map_high_r;

    always_comb begin
        if (hit_low) begin
            rd_data_nxt = map_low_r;
        end else if (hit_high) begin
            rd_data_nxt = map_high_r;
        end else begin
            rd_data_nxt = diffserv_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            map_low_r  <= diffserv_pkg::MAP_LOW_RESET;
            map_high_r <= diffserv_pkg::MAP_HIGH_RESET;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= diffserv_pkg::UNMAPPED_READ;
        end else if (clk_en) begin
            map_low_r  <= map_low_nxt;
            map_high_r <= map_high_nxt;
            wb_ack_o   <= bus_req;
            wb_dat_o   <= bus_req ? rd_data_nxt : diffserv_pkg::UNMAPPED_READ;
        end
    end

    // =====================================================================
    // Priority lookup
    // =====================================================================
    logic [5:0]                     code;
    logic [63:0]                    code_onehot;
    logic [63:0]                    table_bits;
    logic                           is_ip;
    logic                           prio_sel;
    diffserv_pkg::prio_result_type  result_nxt;

    // Both header kinds carry the traffic class in the same byte position.
    assign code        = frame_in.tos[diffserv_pkg::TOS_CODE_MSB:diffserv_pkg::TOS_CODE_LSB];
    assign is_ip       = frame_in.is_ipv4 || frame_in.is_ipv6;
    // Each code line compares the six selected bits with its own index, so exactly one is high.
    for (genvar i = 0; i < diffserv_pkg::CODE_COUNT; i++) begin : g_decode
        assign code_onehot[i] = (code == 6'(i));
    end
    assign table_bits  = {map_high_r, map_low_r};
    assign prio_sel    = |(code_onehot & table_bits);

    assign result_nxt.valid         = frame_in.valid && is_ip;
    assign result_nxt.high_priority = result_nxt.valid && prio_sel;
    assign result_nxt.code          = code;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_out <= '0;
        end else if (clk_en) begin
            result_out <= result_nxt;
        end
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    sequence s_write_low;
        clk_en && wr_take && hit_low && (wb_sel_i == 4'hF);
    endsequence

    sequence s_write_high;
        clk_en && wr_take && hit_high && (wb_sel_i == 4'hF);
    endsequence

    property p_low_bit;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && frame_in.valid && is_ip && !code[5])
        |=> (result_out.high_priority == $past(map_low_r[code[4:0]]));
    endproperty
    a_low_bit: assert property (p_low_bit) else $error("low bank bit not used");

    property p_high_bit;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && frame_in.valid && is_ip && code[5])
        |=> (result_out.high_priority == $past(map_high_r[code[4:0]]));
    endproperty
    a_high_bit: assert property (p_high_bit) else $error("high bank bit not used");

    property p_non_ip;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !is_ip) |=> (!result_out.valid && !result_out.high_priority);
    endproperty
    a_non_ip: assert property (p_non_ip) else $error("result given for non-IP frame");

    property p_ip_valid;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && frame_in.valid && is_ip) |=> result_out.valid;
    endproperty
    a_ip_valid: assert property (p_ip_valid) else $error("IP frame got no result");

    property p_code_field;
        @(posedge clk) disable iff (sys_rst)
        clk_en |=> (result_out.code == $past(frame_in.tos[7:2]));
    endproperty
    a_code_field: assert property (p_code_field) else $error("wrong code taken");

    property p_zero_low;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && map_low_r == 32'h0000_0000 && map_high_r == 32'h0000_0000)
        |=> !result_out.high_priority;
    endproperty
    a_zero_low: assert property (p_zero_low) else $error("high priority from empty table");

    property p_write_low;
        @(posedge clk) disable iff (sys_rst)
        s_write_low |=> (map_low_r == $past(wb_dat_i)) ##1 (wb_ack_o == 1'b0 || !clk_en);
    endproperty
    a_write_low: assert property (p_write_low) else $error("low map write lost");

    property p_write_high;
        @(posedge clk) disable iff (sys_rst)
        s_write_high |=> (map_high_r == $past(wb_dat_i));
    endproperty
    a_write_high: assert property (p_write_high) else $error("high map write lost");

    property p_read_low;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && bus_req && !wb_we_i && hit_low) |=> (wb_ack_o && wb_dat_o == $past(map_low_r));
    endproperty
    a_read_low: assert property (p_read_low) else $error("low map read wrong");

    // =====================================================================
    // Bus handshake, register hold, freeze and reset assertions
    // =====================================================================
    sequence s_read_high;
        clk_en && bus_req && !wb_we_i && hit_high;
    endsequence

    sequence s_read_none;
        clk_en && bus_req && !wb_we_i && !hit_low && !hit_high;
    endsequence

    sequence s_idle_bus;
        clk_en && !(wb_cyc_i && wb_stb_i);
    endsequence

    property p_read_high;
        @(posedge clk) disable iff (sys_rst)
        s_read_high |=> (wb_ack_o && wb_dat_o == $past(map_high_r));
    endproperty
    a_read_high: assert property (p_read_high) else $error("high map read wrong");

    property p_unmapped_read;
        @(posedge clk) disable iff (sys_rst)
        s_read_none |=> (wb_ack_o && wb_dat_o == diffserv_pkg::UNMAPPED_READ);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read wrong");

    property p_no_ack_idle;
        @(posedge clk) disable iff (sys_rst)
        s_idle_bus |=> !wb_ack_o;
    endproperty
    a_no_ack_idle: assert property (p_no_ack_idle) else $error("ack without request");

    property p_ack_follows;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");

    property p_ack_pulse;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && wb_ack_o) |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_dat_idle;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !bus_req) |=> (wb_dat_o == diffserv_pkg::UNMAPPED_READ);
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

    property p_keep_low;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !(wr_take && hit_low)) |=> $stable(map_low_r);
    endproperty
    a_keep_low: assert property (p_keep_low) else $error("low map changed without write");

    property p_keep_high;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !(wr_take && hit_high)) |=> $stable(map_high_r);
    endproperty
    a_keep_high: assert property (p_keep_high) else $error("high map changed without write");

    property p_freeze_low;
        @(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(map_low_r);
    endproperty
    a_freeze_low: assert property (p_freeze_low) else $error("low map moved while frozen");

    property p_freeze_high;
        @(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(map_high_r);
    endproperty
    a_freeze_high: assert property (p_freeze_high) else $error("high map moved while frozen");

    property p_freeze_ack;
        @(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(wb_ack_o);
    endproperty
    a_freeze_ack: assert property (p_freeze_ack) else $error("ack moved while frozen");

    property p_freeze_dat;
        @(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(wb_dat_o);
    endproperty
    a_freeze_dat: assert property (p_freeze_dat) else $error("read data moved while frozen");

    property p_freeze_result;
        @(posedge clk) disable iff (sys_rst)
        !clk_en |=> $stable(result_out);
    endproperty
    a_freeze_result: assert property (p_freeze_result) else $error("result moved while frozen");

    property p_reset_values;
        @(posedge clk)
        sys_rst |=> (map_low_r == diffserv_pkg::MAP_LOW_RESET
                     && map_high_r == diffserv_pkg::MAP_HIGH_RESET
                     && !wb_ack_o && result_out == '0);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("state not cleared by reset");

    // =====================================================================
    // Lookup assertions
    // =====================================================================
    property p_onehot;
        @(posedge clk) disable iff (sys_rst)
        $onehot(code_onehot);
    endproperty
    a_onehot: assert property (p_onehot) else $error("code decode not one-hot");

    property p_high_needs_valid;
        @(posedge clk) disable iff (sys_rst)
        result_out.high_priority |-> result_out.valid;
    endproperty
    a_high_needs_valid: assert property (p_high_needs_valid) else $error("high without valid");

    property p_invalid_frame;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !frame_in.valid) |=> (!result_out.valid && !result_out.high_priority);
    endproperty
    a_invalid_frame: assert property (p_invalid_frame) else $error("result for idle input");

    property p_ipv4_valid;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && frame_in.valid && frame_in.is_ipv4) |=> result_out.valid;
    endproperty
    a_ipv4_valid: assert property (p_ipv4_valid) else $error("IPv4 frame got no result");

    property p_ipv6_valid;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && frame_in.valid && frame_in.is_ipv6) |=> result_out.valid;
    endproperty
    a_ipv6_valid: assert property (p_ipv6_valid) else $error("IPv6 frame got no result");

endmodule

// ===== diffserv_priority_lookup_tb.sv
module diffserv_priority_lookup_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                           clk = 1'b0;
    logic                           sys_rst = 1'b1;
    logic                           clk_en = 1'b1;
    logic [15:0]                    wb_adr_i = 16'h0000;
    logic [31:0]                    wb_dat_i = 32'h0000_0000;
    logic [3:0]                     wb_sel_i = 4'h0;
    logic                           wb_we_i = 1'b0;
    logic                           wb_cyc_i = 1'b0;
    logic                           wb_stb_i = 1'b0;
    logic [31:0]                    wb_dat_o;
    logic                           wb_ack_o;
    diffserv_pkg::frame_info_type   frame_in = '0;
    diffserv_pkg::prio_result_type  result_out;
    logic [31:0]                    low_r = 32'h5A3C_96E1;
    logic [31:0]                    high_r = 32'hC3A5_0F78;
    logic [31:0]                    rd;
    int                             errors = 0;
    int                             total_checks = 0;

    always #2.5 clk = ~clk;

    diffserv_priority_lookup i_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .frame_in(frame_in), .result_out(result_out));

    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One classic cycle; the request is held until the edge that samples ack high.
    task automatic wb(input logic [15:0] a, input logic we, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_adr_i <= a;
        wb_we_i  <= we;
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("ack", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // Expected result is derived from the bench's own copy of both tables.
    task automatic lk(input logic [7:0] tos, input logic v4, input logic v6, input logic v);
        logic [5:0] c;
        logic       hp;
        logic       ok;
        c  = tos[7:2];
        hp = c[5] ? high_r[c[4:0]] : low_r[c[4:0]];
        ok = v & (v4 | v6);
        @(posedge clk);
        frame_in <= '{valid: v, is_ipv4: v4, is_ipv6: v6, tos: tos};
        repeat (2) @(posedge clk);
        chk("result", {24'h0, ok, ok & hp, c}, {24'h0, result_out});
    endtask

    // With the enable low the result must hold although a new frame is offered.
    task automatic freeze();
        logic [7:0] held;
        @(posedge clk);
        clk_en   <= 1'b0;
        frame_in <= '{valid: 1'b1, is_ipv4: 1'b0, is_ipv6: 1'b1, tos: 8'hFC};
        @(posedge clk);
        held = result_out;
        repeat (3) @(posedge clk);
        chk("frozen result", {24'h0, held}, {24'h0, result_out});
        clk_en <= 1'b1;
        lk(8'hFC, 1'b0, 1'b1, 1'b1);
    endtask

    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic regs_reset();
        wb(diffserv_pkg::MAP_LOW_OFFSET, 1'b0, 32'h0, 4'hF, rd);
        chk("low reset", diffserv_pkg::MAP_LOW_RESET, rd);
        wb(diffserv_pkg::MAP_HIGH_OFFSET, 1'b0, 32'h0, 4'hF, rd);
        chk("high reset", diffserv_pkg::MAP_HIGH_RESET, rd);
    endtask

    task automatic regs_rw();
        wb(diffserv_pkg::MAP_LOW_OFFSET, 1'b1, low_r, 4'hF, rd);
        wb(diffserv_pkg::MAP_HIGH_OFFSET, 1'b1, high_r, 4'hF, rd);
        wb(diffserv_pkg::MAP_HIGH_OFFSET, 1'b1, 32'hFFFF_FFFF, 4'h2, rd);
        high_r[15:8] = 8'hFF;
        wb(diffserv_pkg::MAP_LOW_OFFSET, 1'b0, 32'h0, 4'hF, rd);
        chk("low rw", low_r, rd);
        wb(diffserv_pkg::MAP_HIGH_OFFSET, 1'b0, 32'h0, 4'hF, rd);
        chk("high rw", high_r, rd);
        wb(16'h8308, 1'b1, 32'hFFFF_FFFF, 4'hF, rd);
        wb(16'h8308, 1'b0, 32'h0, 4'hF, rd);
        chk("unmapped", diffserv_pkg::UNMAPPED_READ, rd);
    endtask

    task automatic lookup_all();
        for (int c = 0; c < 64; c++) begin
            lk({c[5:0], c[1:0] ^ 2'b10}, c[0], ~c[0], 1'b1);
        end
        lk(8'h78, 1'b1, 1'b1, 1'b1);
        lk(8'h78, 1'b0, 1'b0, 1'b1);
        lk(8'h78, 1'b1, 1'b0, 1'b0);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        test_done();
    end

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        regs_reset();
        regs_rw();
        lookup_all();
        freeze();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        regs_reset();
        low_r = 32'h0;
        high_r = 32'h0;
        lk(8'h7B, 1'b1, 1'b0, 1'b1);
        test_done();
    end
endmodule
